// ### common/tgr_pkg.sv
// Shared constants and types of the teletext gearing router
`default_nettype none

package tgr_pkg;

  // ************************************************************
  // Line format
  // ************************************************************
  // Framing code as held in the shift register, first bit received in bit 0
  localparam logic [7:0] FRAMING_CODE = 8'h27;
  localparam int BYTE_BITS = 8;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [5:0] ADDR_BYTE_0 = 6'h00;
  localparam logic [5:0] ADDR_BYTE_1 = 6'h01;
  localparam logic [5:0] FIRST_DATA_BYTE = 6'h02;
  localparam logic [5:0] LAST_DATA_BYTE = 6'h21;

  // ************************************************************
  // Bit positions inside the two address bytes
  // ************************************************************
  localparam logic [2:0] GEAR_POS = 3'h5;
  localparam logic [2:0] ROW0_POS = 3'h7;
  localparam logic [2:0] ROW1_POS = 3'h1;
  localparam logic [2:0] ROW2_POS = 3'h3;
  localparam logic [2:0] ROW3_POS = 3'h5;
  localparam logic [2:0] ROW4_POS = 3'h7;

  // ************************************************************
  // Page RAM routing
  // ************************************************************
  localparam logic [5:0] MAX_WRITES = 6'h20;
  localparam logic [5:0] FILL_COL_BASE = 6'h20;
  localparam logic [4:0] HEADER_ALIAS_ROW = 5'h01;
  localparam logic [4:0] HEADER_ROW = 5'h00;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam real BIT_RATE_MBPS = 5.727272;
  localparam real CLK_MHZ = 20.0;
  // Least core clocks between two data clock edges, rounded down
  localparam int CLKS_PER_BIT = int'($floor(CLK_MHZ / BIT_RATE_MBPS));

  typedef enum logic [1:0] {
    TGR_HUNT = 2'b00,
    TGR_ADDR = 2'b01,
    TGR_DATA = 2'b10,
    TGR_DONE = 2'b11
  } tgr_state_e;

  typedef struct packed {
    tgr_state_e st;
    logic clk_prev;
    logic [7:0] sr;
    logic [2:0] bit_cnt;
    logic [5:0] byte_cnt;
    logic gear;
    logic [4:0] row;
    logic [5:0] wr_cnt;
    logic acq_data;
    logic acq_stb;
    logic ram_we;
    logic [4:0] ram_row;
    logic [5:0] ram_col;
  } tgr_main_s;

  typedef struct packed {
    logic [7:0] stage;
  } tgr_delay_s;

endpackage : tgr_pkg

`default_nettype wire

// ### src/tgr_byte_delay.sv
// One byte period delay line for the serial teletext stream
`timescale 1ns/10ps
`default_nettype none

module tgr_byte_delay
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Serial stream
  input wire logic shift_en,
  input wire logic bit_in,
  output logic bit_out
);

  tgr_pkg::tgr_delay_s q_ff;
  tgr_pkg::tgr_delay_s nxt_q;

  always_comb
  begin
    nxt_q = q_ff;
    if (shift_en)
    begin
      nxt_q.stage = {bit_in, q_ff.stage[7:1]};
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      q_ff <= '0;
    end
    else
    begin
      q_ff <= nxt_q;
    end
  end

  // Oldest bit, leaving on the next shift
  assign bit_out = q_ff.stage[0];

endmodule : tgr_byte_delay

`default_nettype wire

// ### src/tgr_gearing_router.sv
// Gearing, byte delay and page RAM address routing for 525-line teletext
//
// Notes on behaviour
// R1 - Accept serial bytes on the data clock
// R2 - Pass at most 32 write enables per line
// R3 - Gearing one means fill-in, zero left-hand
// R4 - Fill-in groups go to last eight columns
// R5 - Left-hand bytes go to transmitted row
// R6 - Fill-in start row from line row address
// R7 - Row address one starts fill-in at zero
// R8 - Gearing bit always forwarded as zero
// R9 - Two low magazine bits carry the magazine
// R10 - Stream delayed one byte before forwarding
// R11 - Gearing flag held per line, cleared between
// R12 - Fill-in row advances every eight bytes
// R13 - Left-hand addresses pass through unchanged
// R14 - Count bytes only after framing code found
// R15 - Fill-in confined to four consecutive rows
`timescale 1ns/10ps
`default_nettype none

module tgr_gearing_router
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // From the video input processor
  input wire logic data_clk,
  input wire logic data_bit,
  input wire logic line_start,
  // To the acquisition chip
  output logic acq_data,
  output logic acq_bit_stb,
  // From the acquisition chip, write side
  input wire logic char_write_ok,
  input wire logic [4:0] acq_row,
  input wire logic [5:0] acq_col,
  // To the page RAM
  output logic ram_we,
  output logic [4:0] ram_row,
  output logic [5:0] ram_col,
  // Line status
  output logic gear_flag
);

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic at_pos(
    input tgr_pkg::tgr_main_s q,
    input tgr_pkg::tgr_state_e st,
    input logic [5:0] byte_idx,
    input logic [2:0] bit_idx
  );
    at_pos = (q.st == st) && (q.byte_cnt == byte_idx) && (q.bit_cnt == bit_idx);
  endfunction : at_pos

  // Row zero is the header, so a start on row one is moved to zero
  function automatic logic [4:0] fill_start(input logic [4:0] row);
    fill_start = (row == tgr_pkg::HEADER_ALIAS_ROW) ? tgr_pkg::HEADER_ROW : row; // R7
  endfunction : fill_start

  // ************************************************************
  // State
  // ************************************************************
  tgr_pkg::tgr_main_s q_ff;
  tgr_pkg::tgr_main_s nxt_q;
  logic bit_stb;
  logic shift_ok;
  logic delayed_bit;
  logic [4:0] start_row;

  assign bit_stb = data_clk & ~q_ff.clk_prev; // R1
  // A bit refused by line start must not slip the delay against the strobes
  assign shift_ok = bit_stb & ~line_start; // R10
  assign start_row = fill_start(q_ff.row); // R6

  tgr_byte_delay tgr_byte_delay_inst
  (
    .core_clk(core_clk),
    .reset(reset),
    .shift_en(shift_ok),
    .bit_in(data_bit),
    .bit_out(delayed_bit)
  );

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb
  begin
    nxt_q = q_ff;
    nxt_q.clk_prev = data_clk;
    nxt_q.acq_stb = 1'b0;
    nxt_q.ram_we = 1'b0;
    if (line_start)
    begin
      // New line restarts framing search and drops last line's gearing
      nxt_q.st = tgr_pkg::TGR_HUNT;
      nxt_q.bit_cnt = '0;
      nxt_q.byte_cnt = '0;
      nxt_q.gear = 1'b0; // R11
      nxt_q.row = '0;
      nxt_q.wr_cnt = '0;
    end
    else
    begin
      if (bit_stb)
      begin
        nxt_q.sr = {data_bit, q_ff.sr[7:1]};
        nxt_q.acq_stb = 1'b1;
        // Byte now leaving the delay is the first address byte
        if (at_pos(q_ff, tgr_pkg::TGR_ADDR, tgr_pkg::ADDR_BYTE_1, tgr_pkg::GEAR_POS))
        begin
          // Magazine is left on the two low bits only
          nxt_q.acq_data = 1'b0; // R8 R9
        end
        else
        begin
          nxt_q.acq_data = delayed_bit; // R10
        end
        unique case (q_ff.st)
          tgr_pkg::TGR_HUNT:
          begin
            if ({data_bit, q_ff.sr[7:1]} == tgr_pkg::FRAMING_CODE)
            begin
              nxt_q.st = tgr_pkg::TGR_ADDR; // R14
              nxt_q.bit_cnt = '0;
              nxt_q.byte_cnt = tgr_pkg::ADDR_BYTE_0;
            end
          end
          tgr_pkg::TGR_ADDR:
          begin
            if (at_pos(q_ff, tgr_pkg::TGR_ADDR, tgr_pkg::ADDR_BYTE_0, tgr_pkg::GEAR_POS))
            begin
              nxt_q.gear = q_ff.gear | data_bit; // R3 R11
            end
            if (at_pos(q_ff, tgr_pkg::TGR_ADDR, tgr_pkg::ADDR_BYTE_0, tgr_pkg::ROW0_POS))
            begin
              nxt_q.row[0] = data_bit; // R6
            end
            if (q_ff.byte_cnt == tgr_pkg::ADDR_BYTE_1)
            begin
              unique case (q_ff.bit_cnt)
                tgr_pkg::ROW1_POS: nxt_q.row[1] = data_bit;
                tgr_pkg::ROW2_POS: nxt_q.row[2] = data_bit;
                tgr_pkg::ROW3_POS: nxt_q.row[3] = data_bit;
                tgr_pkg::ROW4_POS: nxt_q.row[4] = data_bit;
                default: nxt_q.row = q_ff.row;
              endcase
            end
            nxt_q.bit_cnt = q_ff.bit_cnt + 3'h1;
            if (q_ff.bit_cnt == tgr_pkg::LAST_BIT)
            begin
              nxt_q.byte_cnt = q_ff.byte_cnt + 6'h01;
              if (q_ff.byte_cnt == tgr_pkg::ADDR_BYTE_1)
              begin
                nxt_q.st = tgr_pkg::TGR_DATA;
              end
            end
          end
          tgr_pkg::TGR_DATA:
          begin
            nxt_q.bit_cnt = q_ff.bit_cnt + 3'h1;
            if (q_ff.bit_cnt == tgr_pkg::LAST_BIT)
            begin
              nxt_q.byte_cnt = q_ff.byte_cnt + 6'h01;
              if (q_ff.byte_cnt == tgr_pkg::LAST_DATA_BYTE)
              begin
                nxt_q.st = tgr_pkg::TGR_DONE;
              end
            end
          end
          tgr_pkg::TGR_DONE:
          begin
            nxt_q.st = tgr_pkg::TGR_DONE;
          end
        endcase
      end
      // Write enables beyond the line's quota never reach the RAM
      if (char_write_ok && (q_ff.wr_cnt < tgr_pkg::MAX_WRITES)) // R2
      begin
        nxt_q.ram_we = 1'b1;
        nxt_q.wr_cnt = q_ff.wr_cnt + 6'h01;
        if (q_ff.gear)
        begin
          // Group index is wr_cnt[4:3], so at most four rows are touched
          nxt_q.ram_row = start_row + {3'h0, q_ff.wr_cnt[4:3]}; // R4 R12 R15
          nxt_q.ram_col = tgr_pkg::FILL_COL_BASE + {3'h0, q_ff.wr_cnt[2:0]}; // R4
        end
        else
        begin
          nxt_q.ram_row = acq_row; // R5 R13
          nxt_q.ram_col = acq_col; // R13
        end
      end
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      q_ff <= '0;
    end
    else
    begin
      q_ff <= nxt_q;
    end
  end

  assign acq_data = q_ff.acq_data;
  assign acq_bit_stb = q_ff.acq_stb;
  assign ram_we = q_ff.ram_we;
  assign ram_row = q_ff.ram_row;
  assign ram_col = q_ff.ram_col;
  assign gear_flag = q_ff.gear;

endmodule : tgr_gearing_router

`default_nettype wire

// ### bench/tgr_gearing_router_chk.sv
// Port assertions for the teletext gearing router
`timescale 1ns/10ps
`default_nettype none

module tgr_gearing_router_chk
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Serial side
  input wire logic data_clk,
  input wire logic data_bit,
  input wire logic line_start,
  input wire logic acq_data,
  input wire logic acq_bit_stb,
  // Write side
  input wire logic char_write_ok,
  input wire logic [4:0] acq_row,
  input wire logic [5:0] acq_col,
  input wire logic ram_we,
  input wire logic [4:0] ram_row,
  input wire logic [5:0] ram_col,
  input wire logic gear_flag
);
  logic [6:0] we_cnt_ff;

  default clocking @(posedge core_clk);
  endclocking
  default disable iff (reset);

  // Writes seen since the last line start
  always_ff @(posedge core_clk)
  begin
    if (reset || line_start)
      we_cnt_ff <= 7'h00;
    else if (ram_we)
      we_cnt_ff <= we_cnt_ff + 7'h01;
  end

  chk_bit_strobe: assert property (!line_start && $rose(data_clk) |=> acq_bit_stb)
    else $error("No strobe after a data clock rise");
  chk_strobe_cause: assert property (acq_bit_stb |-> $past(data_clk) && !$past(line_start))
    else $error("Strobe without an accepted bit");
  chk_strobe_gap: assert property (acq_bit_stb |=> !acq_bit_stb)
    else $error("Strobe longer than one cycle");
  chk_data_hold: assert property (!acq_bit_stb |-> $stable(acq_data))
    else $error("Forwarded bit changed without strobe");
  chk_flag_clear: assert property (line_start |=> !gear_flag)
    else $error("Gearing flag not cleared by line start");
  chk_flag_set: assert property ($rose(gear_flag) |-> acq_bit_stb)
    else $error("Gearing flag set off a bit strobe");
  chk_we_cause: assert property (ram_we |-> $past(char_write_ok) && !$past(line_start))
    else $error("RAM write without accepted enable");
  chk_we_limit: assert property (ram_we |-> we_cnt_ff < 7'h20)
    else $error("More than 32 RAM writes in one line");
  chk_left_pass: assert property (ram_we && !$past(gear_flag)
    |-> ram_row == $past(acq_row) && ram_col == $past(acq_col))
    else $error("Left-hand address altered");
  chk_fill_col: assert property (ram_we && $past(gear_flag)
    |-> ram_col >= 6'h20 && ram_col <= 6'h27)
    else $error("Fill-in column outside last eight");
endmodule : tgr_gearing_router_chk

bind tgr_gearing_router tgr_gearing_router_chk tgr_gearing_router_chk_inst (.core_clk, .reset,
  .data_clk, .data_bit, .line_start, .acq_data, .acq_bit_stb, .char_write_ok, .acq_row,
  .acq_col, .ram_we, .ram_row, .ram_col, .gear_flag);

`default_nettype wire

// ### bench/tgr_vip_model.sv
// Behavioural video input processor that serialises teletext bytes
`timescale 1ns/10ps
`default_nettype none

module tgr_vip_model
(
  // Clock
  input wire logic core_clk,
  // Serial stream
  output logic data_clk,
  output logic data_bit
);
  logic slow_ff;

  initial
  begin
    data_clk = 1'b0;
    data_bit = 1'b0;
    slow_ff = 1'b0;
  end

  // Bit 0 first; periods of 3 and 4 clocks average the line bit rate
  task automatic send_byte(input logic [7:0] val);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge core_clk);
      #2;
      data_bit = val[i];
      data_clk = 1'b1;
      repeat (2) @(posedge core_clk);
      #2;
      data_clk = 1'b0;
      // Latch hold is over, so the line no longer shows the bit
      data_bit = ~data_bit;
      slow_ff = ~slow_ff;
      if (slow_ff)
        @(posedge core_clk);
    end
  endtask : send_byte
endmodule : tgr_vip_model

`default_nettype wire

// ### bench/tb_teletext_gearing_router.sv
// Self-checking bench for the teletext gearing router
`timescale 1ns/10ps
`default_nettype none

module tb_teletext_gearing_router;
  logic core_clk, reset, data_clk, data_bit, line_start, acq_data, acq_bit_stb;
  logic char_write_ok, ram_we, gear_flag;
  logic [4:0] acq_row, ram_row;
  logic [5:0] acq_col, ram_col;
  logic [31:0] rng;
  int bad_count, num_checks;
  logic exp_bits[$];
  logic [10:0] exp_wr[$];

  tgr_gearing_router tgr_gearing_router_inst (.core_clk, .reset, .data_clk, .data_bit,
    .line_start, .acq_data, .acq_bit_stb, .char_write_ok, .acq_row, .acq_col, .ram_we,
    .ram_row, .ram_col, .gear_flag);
  tgr_vip_model tgr_vip_model_inst (.core_clk, .data_clk, .data_bit);

  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  function automatic void step_rand();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
  endfunction : step_rand

  // Fill-in row 1 stands for row 0, which only the header may use
  function automatic logic [10:0] exp_addr(input logic gear, input logic [4:0] row,
    input int n, input logic [10:0] acq);
    logic [4:0] base;
    base = (row == 5'h01) ? 5'h00 : row;
    if (!gear)
      return acq;
    return {5'(base + 5'(n / 8)), 6'(6'h20 + 6'(n % 8))};
  endfunction : exp_addr

  task automatic check_val(input logic [10:0] got, input logic [10:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_val

  task automatic give_verdict();
    $display("Checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : give_verdict

  // Registered pulses are looked at mid-cycle, where they have settled
  always @(negedge core_clk)
  begin
    if (acq_bit_stb === 1'b1)
      check_val(11'(acq_data), 11'(exp_bits.pop_front()));
    if (ram_we === 1'b1)
      check_val({ram_row, ram_col}, exp_wr.pop_front());
  end

  task automatic send_line(input logic gear, input logic [4:0] row);
    logic [7:0] b[37];
    b[0] = 8'h55;
    b[1] = 8'h55;
    b[2] = 8'h27;
    for (int k = 3; k < 37; k++)
    begin
      step_rand();
      b[k] = rng[7:0];
    end
    b[3][5] = gear;
    b[3][7] = row[0];
    {b[4][7], b[4][5], b[4][3], b[4][1]} = row[4:1];
    @(posedge core_clk);
    #2;
    line_start = 1'b1;
    @(posedge core_clk);
    #2;
    line_start = 1'b0;
    check_val(11'(gear_flag), 11'h000);
    for (int k = 0; k < 37; k++)
    begin
      for (int i = 0; i < 8; i++)
        exp_bits.push_back((k == 3 && i == 5) ? 1'b0 : b[k][i]);
      tgr_vip_model_inst.send_byte(b[k]);
    end
    check_val(11'(gear_flag), 11'(gear));
    // Two writes past the limit must be swallowed
    for (int n = 0; n < 34; n++)
    begin
      step_rand();
      acq_row = rng[4:0];
      acq_col = rng[10:5];
      char_write_ok = 1'b1;
      if (n < 32)
        exp_wr.push_back(exp_addr(gear, row, n, {rng[4:0], rng[10:5]}));
      @(posedge core_clk);
      #2;
    end
    char_write_ok = 1'b0;
    repeat (3) @(posedge core_clk);
    $display("Line done gear %0d row %0d", gear, row);
  endtask : send_line

  initial
  begin
    logic [4:0] row;
    rng = 32'h54;
    bad_count = 0;
    num_checks = 0;
    reset = 1'b1;
    line_start = 1'b0;
    char_write_ok = 1'b0;
    acq_row = 5'h00;
    acq_col = 6'h00;
    repeat (8) exp_bits.push_back(1'b0);
    repeat (4) @(posedge core_clk);
    #2;
    reset = 1'b0;
    check_val(11'({acq_bit_stb, ram_we, gear_flag}), 11'h000);
    // Row 30 fill-in wraps past row 31
    for (int k = 0; k < 5; k++)
    begin
      step_rand();
      row = (k == 1 || k == 4) ? 5'h01 : (k == 3) ? 5'h1E : rng[20:16];
      send_line(k >= 1 && k <= 3, row);
    end
    check_val(11'(exp_bits.size()), 11'h008);
    check_val(11'(exp_wr.size()), 11'h000);
    give_verdict();
  end

  initial
  begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    give_verdict();
  end
endmodule : tb_teletext_gearing_router

`default_nettype wire
